/* File: src/lcra_pkg.sv */
// Package for the host-facing control register adapter of a function engine.
// Assumes a single 50 MHz clock shared by the register bus and the engine.
`default_nettype none

package lcra_pkg;

	// ==========================================================
	// Bus geometry
	localparam int          AXI_ADDR_W   = 8;               // Register bus address width
	localparam int          AXI_DATA_W   = 32;              // Register bus data width
	localparam int          AXI_STRB_W   = 4;               // Byte enables
	localparam int          ARG_W        = 8;               // Width of each argument

	// ==========================================================
	// Memory-master address width option
	localparam logic        WIDE_ADDRESS_OPTION = 1'b1;     // Wide addresses on
	localparam int          MM_ADDR_W_WIDE      = 64;       // Width with option on
	localparam int          MM_ADDR_W_NARROW    = 32;       // Width with option off
	localparam int          MM_ADDR_W = WIDE_ADDRESS_OPTION ? MM_ADDR_W_WIDE : MM_ADDR_W_NARROW;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0]  OFS_BLOCK_CONTROL_STATUS       = 8'h00;
	localparam logic [7:0]  OFS_IRQ_GLOBAL_ENABLE          = 8'h04; // Reads zero
	localparam logic [7:0]  OFS_IRQ_ENABLE                 = 8'h08; // Reads zero
	localparam logic [7:0]  OFS_IRQ_STATUS                 = 8'h0C;
	localparam logic [7:0]  OFS_FIRST_ARGUMENT_VALUE       = 8'h10;
	localparam logic [7:0]  OFS_SECOND_ARGUMENT_VALUE      = 8'h18;
	localparam logic [7:0]  OFS_SECOND_ARGUMENT_VALID      = 8'h1C;
	localparam logic [7:0]  OFS_THIRD_ARGUMENT_INPUT       = 8'h20;
	localparam logic [7:0]  OFS_RESERVED_GAP_WORD          = 8'h24;
	localparam logic [7:0]  OFS_THIRD_ARGUMENT_OUTPUT      = 8'h28;
	localparam logic [7:0]  OFS_THIRD_ARGUMENT_OUTPUT_VALID = 8'h2C;
	localparam logic [7:0]  OFS_LAST_MAPPED                = 8'h2C;

	// ==========================================================
	// Control word bit positions
	localparam int          CTL_RUN_REQUEST   = 0;
	localparam int          CTL_COMPLETION    = 1;
	localparam int          CTL_ENGINE_QUIET  = 2;
	localparam int          CTL_ACCEPT_NEXT   = 3;
	localparam int          CTL_PROCEED       = 4;
	// Interrupt status bit positions
	localparam int          ISR_COMPLETION    = 0;
	localparam int          ISR_ACCEPT_NEXT   = 1;
	// Valid flag bit position in the valid registers (0x1C, 0x2C)
	localparam int          VLD_BIT           = 0;

	// ==========================================================
	// Responses and reset values
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;
	localparam logic [7:0]  ARG_RESET   = 8'h00;

endpackage

`default_nettype wire

/* File: src/lcra_adapter.sv */
// Control register adapter between a host on an AXI4-Lite bus and a function engine.
// Assumes engine handshake signals are synchronous to clk; no input synchroniser needed.
`timescale 1ns/1ps
`default_nettype none

// Operation
// RULE1: Memory-master address bus 64 bits by default
// RULE2: Option off gives 32 bits, all ports
// RULE3: Host writes held in adapter registers
// RULE4: Start/stop control, arguments, return, pointer offsets
// RULE5: Arguments placed sequentially from offset 0x10
// RULE6: One 32-bit word per item, upper unused
// RULE7: Handshaked input: data 0x18, valid 0x1C
// RULE8: Inout: 0x20 in, 0x24 gap, 0x28/0x2C out
// RULE9: Host starts at 0x00 then writes arguments
// RULE10: Engine stalls until handshaked input valid set
// RULE11: Consuming handshaked input clears its valid
// RULE12: Result stored and output valid set
// RULE13: Completion bit set after host reads output
// RULE14: All arguments share one register interface
// RULE15: Control holds start, completion, quiet, ready, proceed
// RULE16: Output valid and interrupt status clear on read
// RULE17: Reserved bits and words read zero
module lcra_adapter (
	input  wire logic                          clk,
	input  wire logic                          nrst,
	// AXI4-Lite write address
	input  wire logic [lcra_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output var  logic                          s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [lcra_pkg::AXI_DATA_W-1:0] s_axi_wdata,
	input  wire logic [lcra_pkg::AXI_STRB_W-1:0] s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output var  logic                          s_axi_wready,
	// AXI4-Lite write response
	output var  logic [1:0]                    s_axi_bresp,
	output var  logic                          s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [lcra_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output var  logic                          s_axi_arready,
	// AXI4-Lite read data
	output var  logic [lcra_pkg::AXI_DATA_W-1:0] s_axi_rdata,
	output var  logic [1:0]                    s_axi_rresp,
	output var  logic                          s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	// Engine block control
	output var  logic                          run_request_bit,
	output var  logic                          proceed_bit,
	input  wire logic                          completion_flag,
	input  wire logic                          engine_quiet_flag,
	input  wire logic                          accept_next_flag,
	// Engine arguments
	output var  logic [lcra_pkg::ARG_W-1:0]    first_arg,
	output var  logic [lcra_pkg::ARG_W-1:0]    second_arg,
	output var  logic                          second_arg_valid,
	input  wire logic                          second_arg_consume,
	output var  logic [lcra_pkg::ARG_W-1:0]    third_arg_in,
	input  wire logic [lcra_pkg::ARG_W-1:0]    third_arg_out,
	input  wire logic                          third_arg_out_strobe,
	// Memory-master address width in use
	output var  logic                          wide_address_option
);
	import lcra_pkg::*;

	// ==========================================================
	// State record
	typedef struct packed {
		logic                  awready;      // Write accept pulse
		logic                  wready;       // Data accept pulse
		logic                  bvalid;       // Write response pending
		logic [1:0]            bresp;        // Write response code
		logic                  arready;      // Read accept pulse
		logic                  rvalid;       // Read data pending
		logic [1:0]            rresp;        // Read response code
		logic [AXI_DATA_W-1:0] rdata;        // Read data word
		logic                  run;          // Run request bit
		logic                  proceed;      // Proceed pulse
		logic                  done_pend;    // Engine done, awaiting result read
		logic                  completion;   // Completion flag, clear on read
		logic                  accept;       // Accept-next flag, clear on read
		logic [1:0]            isr;          // Interrupt status bits
		logic [ARG_W-1:0]      a_val;        // First argument
		logic [ARG_W-1:0]      b_val;        // Second argument
		logic                  b_vld;        // Second argument valid
		logic [ARG_W-1:0]      ci_val;       // Third argument input
		logic [ARG_W-1:0]      co_val;       // Third argument output
		logic                  co_vld;       // Third argument output valid
		logic                  wide;         // Address width option
	} lcra_state_s;

	lcra_state_s st_r;   // Registered state
	lcra_state_s st_nxt; // Next state

	// ==========================================================
	// Bus access qualifiers
	logic wr_go; // Write taken this cycle
	logic rd_go; // Read taken this cycle
	assign wr_go = s_axi_awvalid && s_axi_wvalid && !st_r.bvalid && !st_r.awready;
	assign rd_go = s_axi_arvalid && !st_r.rvalid && !st_r.arready;

	// ==========================================================
	// Next-state logic
	always_comb begin
		logic [7:0]  wa;     // Write address
		logic [7:0]  ra;     // Read address
		logic [31:0] rword;  // Read word before registering
		logic        rmap;   // Read address mapped
		logic        wmap;   // Write address mapped
		wa    = s_axi_awaddr;
		ra    = s_axi_araddr;
		rword = WORD_ZERO;
		rmap  = (ra <= OFS_LAST_MAPPED) && (ra[1:0] == 2'h0);
		wmap  = (wa <= OFS_LAST_MAPPED) && (wa[1:0] == 2'h0);
		st_nxt = st_r;

		// Handshake pulses drop after one cycle
		st_nxt.awready = 1'b0;
		st_nxt.wready  = 1'b0;
		st_nxt.arready = 1'b0;
		st_nxt.proceed = 1'b0;

		// Response completion
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end

		// Engine-side events (hardware clears applied first, writes below)
		if (st_r.run && accept_next_flag) begin
			st_nxt.run = 1'b0;                               // Clear on handshake [RULE15]
		end
		if (second_arg_consume) begin
			st_nxt.b_vld = 1'b0;                             // Consumed input [RULE11]
		end

		// Read side: decode and clear-on-read effects
		if (rd_go) begin
			st_nxt.arready = 1'b1;
			st_nxt.rvalid  = 1'b1;
			st_nxt.rresp   = rmap ? RESP_OKAY : RESP_SLVERR;
			if (ra == OFS_BLOCK_CONTROL_STATUS) begin
				rword[CTL_RUN_REQUEST]  = st_r.run;           // [RULE15]
				rword[CTL_COMPLETION]   = st_r.completion;
				rword[CTL_ENGINE_QUIET] = engine_quiet_flag;
				rword[CTL_ACCEPT_NEXT]  = st_r.accept;
				st_nxt.completion = 1'b0;
				st_nxt.accept     = 1'b0;
			end else if (ra == OFS_IRQ_STATUS) begin
				rword[1:0] = st_r.isr;
				st_nxt.isr = 2'h0;                              // Clear on read [RULE16]
			end else if (ra == OFS_FIRST_ARGUMENT_VALUE) begin
				rword[ARG_W-1:0] = st_r.a_val;                  // [RULE6]
			end else if (ra == OFS_SECOND_ARGUMENT_VALUE) begin
				rword[ARG_W-1:0] = st_r.b_val;                  // [RULE7]
			end else if (ra == OFS_SECOND_ARGUMENT_VALID) begin
				rword[VLD_BIT] = st_r.b_vld;                    // [RULE7]
			end else if (ra == OFS_THIRD_ARGUMENT_INPUT) begin
				rword[ARG_W-1:0] = st_r.ci_val;                 // [RULE8]
			end else if (ra == OFS_THIRD_ARGUMENT_OUTPUT) begin
				rword[ARG_W-1:0] = st_r.co_val;                 // [RULE8]
			end else if (ra == OFS_THIRD_ARGUMENT_OUTPUT_VALID) begin
				rword[VLD_BIT] = st_r.co_vld;
				st_nxt.co_vld  = 1'b0;                          // Clear on read [RULE16]
			end else begin
				rword = WORD_ZERO;                              // Gap words read zero [RULE17]
			end
			st_nxt.rdata = rword;
		end

		// Write side: capture host values in adapter registers
		if (wr_go) begin
			st_nxt.awready = 1'b1;
			st_nxt.wready  = 1'b1;
			st_nxt.bvalid  = 1'b1;
			st_nxt.bresp   = wmap ? RESP_OKAY : RESP_SLVERR;
			if (wa == OFS_BLOCK_CONTROL_STATUS) begin
				if (s_axi_wstrb[0] && s_axi_wdata[CTL_RUN_REQUEST]) begin
					st_nxt.run = 1'b1;                          // Host start [RULE9]
				end
				if (s_axi_wstrb[0] && s_axi_wdata[CTL_PROCEED]) begin
					st_nxt.proceed = 1'b1;                      // Self-clearing [RULE15]
				end
			end else if (wa == OFS_IRQ_STATUS) begin
				if (s_axi_wstrb[0]) begin
					st_nxt.isr = st_nxt.isr ^ s_axi_wdata[1:0];  // Toggle on write [RULE16]
				end
			end else if (wa == OFS_FIRST_ARGUMENT_VALUE) begin
				if (s_axi_wstrb[0]) begin
					st_nxt.a_val = s_axi_wdata[ARG_W-1:0];       // [RULE3] [RULE5]
				end
			end else if (wa == OFS_SECOND_ARGUMENT_VALUE) begin
				if (s_axi_wstrb[0]) begin
					st_nxt.b_val = s_axi_wdata[ARG_W-1:0];       // [RULE3] [RULE7]
				end
			end else if (wa == OFS_SECOND_ARGUMENT_VALID) begin
				if (s_axi_wstrb[0] && s_axi_wdata[VLD_BIT]) begin
					st_nxt.b_vld = 1'b1;                        // Host set wins [RULE10]
				end
			end else if (wa == OFS_THIRD_ARGUMENT_INPUT) begin
				if (s_axi_wstrb[0]) begin
					st_nxt.ci_val = s_axi_wdata[ARG_W-1:0];      // [RULE3] [RULE8]
				end
			end else begin
				st_nxt.a_val = st_nxt.a_val;                    // Read-only or gap: no effect [RULE17]
			end
		end

		// Result capture; set wins over clear-on-read
		if (third_arg_out_strobe) begin
			st_nxt.co_val = third_arg_out;                      // [RULE12]
			st_nxt.co_vld = 1'b1;                               // [RULE12]
		end

		// Engine completion waits for the host to collect the result
		if (completion_flag) begin
			st_nxt.done_pend = 1'b1;
		end
		if ((st_r.done_pend || completion_flag) && !st_nxt.co_vld) begin
			st_nxt.done_pend  = 1'b0;
			st_nxt.completion = 1'b1;                           // [RULE13]
			st_nxt.isr[ISR_COMPLETION] = 1'b1;
		end

		// Accept-next event, set wins
		if (accept_next_flag) begin
			st_nxt.accept = 1'b1;                               // [RULE15]
			st_nxt.isr[ISR_ACCEPT_NEXT] = 1'b1;
		end

		// Address width option applies to every memory-master port
		st_nxt.wide = WIDE_ADDRESS_OPTION;                      // [RULE1] [RULE2]
	end

	// ==========================================================
	// State register, synchronous active-low reset
	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_r       <= '0;
			st_r.bresp <= RESP_OKAY;
			st_r.rresp <= RESP_OKAY;
			st_r.a_val <= ARG_RESET;
			st_r.b_val <= ARG_RESET;
			st_r.ci_val <= ARG_RESET;
			st_r.co_val <= ARG_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// Outputs straight from the state register; single shared interface
	assign s_axi_awready       = st_r.awready;             // [RULE14]
	assign s_axi_wready        = st_r.wready;
	assign s_axi_bresp         = st_r.bresp;
	assign s_axi_bvalid        = st_r.bvalid;
	assign s_axi_arready       = st_r.arready;
	assign s_axi_rdata         = st_r.rdata;
	assign s_axi_rresp         = st_r.rresp;
	assign s_axi_rvalid        = st_r.rvalid;
	assign run_request_bit     = st_r.run;                 // [RULE4]
	assign proceed_bit         = st_r.proceed;
	assign first_arg           = st_r.a_val;               // [RULE3]
	assign second_arg          = st_r.b_val;
	assign second_arg_valid    = st_r.b_vld;               // Engine gates on this [RULE10]
	assign third_arg_in        = st_r.ci_val;
	assign wide_address_option = st_r.wide;                // [RULE1]

endmodule

`default_nettype wire

/* File: test/lcra_adapter_sva.sv */
// Checker for the host-facing control register adapter.
// Assumes one clock and the synchronous active-low reset of the design.
`timescale 1ns/1ps
`default_nettype none
module lcra_adapter_sva (
	input wire logic                              clk,
	input wire logic                              nrst,
	input wire logic [lcra_pkg::AXI_ADDR_W-1:0]   s_axi_awaddr,
	input wire logic                              s_axi_awvalid,
	input wire logic                              s_axi_awready,
	input wire logic                              s_axi_wvalid,
	input wire logic                              s_axi_wready,
	input wire logic [1:0]                        s_axi_bresp,
	input wire logic                              s_axi_bvalid,
	input wire logic [lcra_pkg::AXI_ADDR_W-1:0]   s_axi_araddr,
	input wire logic                              s_axi_arvalid,
	input wire logic                              s_axi_arready,
	input wire logic [lcra_pkg::AXI_DATA_W-1:0]   s_axi_rdata,
	input wire logic                              s_axi_rvalid,
	input wire logic                              run_request_bit,
	input wire logic                              proceed_bit,
	input wire logic                              accept_next_flag,
	input wire logic                              second_arg_valid,
	input wire logic                              second_arg_consume,
	input wire logic                              wide_address_option
);
	import lcra_pkg::*;
	// ======
	// Requests taken at this edge
	logic wtake;  // Write accepted
	logic rtake;  // Read accepted
	assign wtake = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
	assign rtake = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// ======
	// Properties
	property p_wide; $past(nrst) |-> wide_address_option; endproperty
	property p_wr; wtake |=> s_axi_awready && s_axi_wready && s_axi_bvalid; endproperty
	property p_unm; wtake && s_axi_awaddr > 8'h2C |=> s_axi_bresp == RESP_SLVERR; endproperty
	property p_rd; rtake |=> s_axi_arready ##0 s_axi_rvalid; endproperty
	property p_rsvd; rtake && s_axi_araddr == 8'h24 |=> s_axi_rdata == WORD_ZERO; endproperty
	property p_hold; second_arg_valid && !second_arg_consume |=> second_arg_valid; endproperty
	property p_used; second_arg_consume && !s_axi_awvalid |=> !second_arg_valid; endproperty
	property p_run; run_request_bit && accept_next_flag && !s_axi_awvalid |=> !run_request_bit;
	endproperty
	property p_proc; $rose(proceed_bit) |=> !proceed_bit; endproperty
	a_wide: assert property (p_wide) else $error("wide address option low");
	a_wr: assert property (p_wr) else $error("write not answered");
	a_unm: assert property (p_unm) else $error("unmapped write not refused");
	a_rd: assert property (p_rd) else $error("read not answered");
	a_rsvd: assert property (p_rsvd) else $error("reserved word not zero");
	a_hold: assert property (p_hold) else $error("input valid lost");
	a_used: assert property (p_used) else $error("input valid not cleared");
	a_run: assert property (p_run) else $error("run request not cleared");
	a_proc: assert property (p_proc) else $error("proceed not a pulse");
	// Main scenarios
	c_wr: cover property (wtake);
	c_used: cover property (second_arg_consume && second_arg_valid);
	c_unm: cover property (wtake && s_axi_awaddr > 8'h2C);
endmodule
bind lcra_adapter lcra_adapter_sva chk_u (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .run_request_bit,
	.proceed_bit, .accept_next_flag, .second_arg_valid, .second_arg_consume,
	.wide_address_option);
`default_nettype wire

/* File: test/lcra_host_model.sv */
// Host processor model: register bus master with write and read tasks.
// Assumes the bench calls its tasks; signals move at falling edges only.
`timescale 1ns/1ps
`default_nettype none
module lcra_host_model (
	input  wire logic        clk,
	output var  logic [7:0]  s_axi_awaddr,
	output var  logic        s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output var  logic [31:0] s_axi_wdata,
	output var  logic [3:0]  s_axi_wstrb,
	output var  logic        s_axi_wvalid,
	input  wire logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bready,
	output var  logic [7:0]  s_axi_araddr,
	output var  logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rready
);
	// Idle bus; responses always accepted
	initial begin
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
		{s_axi_bready, s_axi_rready} = 2'h3;
	end
	// One word write, held until ready seen, then released scrambled
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(negedge clk);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} = {a, d, 4'hF};
		{s_axi_awvalid, s_axi_wvalid} = 2'h3;
		do @(negedge clk); while (s_axi_awready !== 1'b1);
		r = s_axi_bresp;
		@(negedge clk);
		{s_axi_awvalid, s_axi_wvalid} = 2'h0;
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} = {~a, ~d, 4'h0};
	endtask
	// One word read, same holding discipline
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(negedge clk);
		s_axi_araddr = a;
		s_axi_arvalid = 1'b1;
		do @(negedge clk); while (s_axi_arready !== 1'b1);
		{d, r} = {s_axi_rdata, s_axi_rresp};
		@(negedge clk);
		s_axi_arvalid = 1'b0;
		s_axi_araddr = ~a;
	endtask
endmodule
`default_nettype wire

/* File: test/lcra_adapter_tb.sv */
// Self-checking bench for the control register adapter.
// Assumes the host model drives the bus; the bench plays the engine.
`timescale 1ns/1ps
`default_nettype none
module lcra_adapter_tb;
	import lcra_pkg::*;
	logic        clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, run_request_bit, proceed_bit, completion_flag;
	logic        engine_quiet_flag, accept_next_flag, second_arg_valid, second_arg_consume;
	logic        third_arg_out_strobe, wide_address_option;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, first_arg, second_arg, third_arg_in, third_arg_out;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	int          miscompares = 0, num_checks = 0, cycles = 0, proceed_cnt = 0;
	// ======
	// Design and host
	lcra_adapter dut_u (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .run_request_bit, .proceed_bit, .completion_flag,
		.engine_quiet_flag, .accept_next_flag, .first_arg, .second_arg, .second_arg_valid,
		.second_arg_consume, .third_arg_in, .third_arg_out, .third_arg_out_strobe,
		.wide_address_option);
	lcra_host_model host_u (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_bresp, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rready);
	// Clock at 50 MHz
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Cycle watchdog and proceed pulse counter
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (proceed_bit === 1'b1) proceed_cnt <= proceed_cnt + 1;
		if (cycles == 4000) begin
			miscompares++;
			summarize();
		end
	end
	// ======
	// Shared helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: saw %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		host_u.wr(a, d, rs);
		chk({30'h0, rs}, {30'h0, er});
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		host_u.rd(a, rv, rs);
		chk(rv, exp);
		chk({30'h0, rs}, {30'h0, er});
	endtask
	task automatic summarize;
		if (miscompares == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ======
	// Scenarios
	task automatic t_start;
		wrc(8'h00, 32'h1, RESP_OKAY);
		chk(run_request_bit, 32'h1);
		accept_next_flag = 1'b1;
		@(negedge clk);
		accept_next_flag = 1'b0;
		engine_quiet_flag = 1'b1;
		chk(run_request_bit, 32'h0);
		rdc(8'h00, 32'hC, RESP_OKAY);
		rdc(8'h00, 32'h4, RESP_OKAY);
		wrc(8'h00, 32'h10, RESP_OKAY);
		chk(proceed_cnt, 32'h1);
	endtask
	task automatic t_args;
		wrc(8'h10, 32'hFFFF_FFA5, RESP_OKAY);
		chk(first_arg, 32'hA5);
		rdc(8'h10, 32'hA5, RESP_OKAY);
		wrc(8'h18, 32'h3C, RESP_OKAY);
		wrc(8'h20, 32'h77, RESP_OKAY);
		chk({second_arg, third_arg_in}, 32'h3C77);
		rdc(8'h14, 32'h0, RESP_OKAY);
		rdc(8'h20, 32'h77, RESP_OKAY);
		wrc(8'h24, 32'hFFFF_FFFF, RESP_OKAY);
		rdc(8'h24, 32'h0, RESP_OKAY);
		wrc(8'h28, 32'hFF, RESP_OKAY);
		rdc(8'h28, 32'h0, RESP_OKAY);
		wrc(8'h30, 32'h1, RESP_SLVERR);
		wrc(8'h12, 32'h1, RESP_SLVERR);
		rdc(8'h30, 32'h0, RESP_SLVERR);
	endtask
	task automatic t_hs;
		wrc(8'h1C, 32'h0, RESP_OKAY);
		chk(second_arg_valid, 32'h0);
		wrc(8'h1C, 32'h1, RESP_OKAY);
		rdc(8'h1C, 32'h1, RESP_OKAY);
		second_arg_consume = 1'b1;
		@(negedge clk);
		second_arg_consume = 1'b0;
		chk(second_arg_valid, 32'h0);
		rdc(8'h1C, 32'h0, RESP_OKAY);
	endtask
	task automatic t_out;
		{third_arg_out, third_arg_out_strobe} = {8'h5A, 1'b1};
		@(negedge clk);
		{third_arg_out, third_arg_out_strobe, completion_flag} = {8'hA5, 1'b0, 1'b1};
		@(negedge clk);
		completion_flag = 1'b0;
		rdc(8'h00, 32'h4, RESP_OKAY);
		rdc(8'h2C, 32'h1, RESP_OKAY);
		rdc(8'h28, 32'h5A, RESP_OKAY);
		rdc(8'h2C, 32'h0, RESP_OKAY);
		rdc(8'h00, 32'h6, RESP_OKAY);
		rdc(8'h00, 32'h4, RESP_OKAY);
		rdc(8'h0C, 32'h3, RESP_OKAY);
		rdc(8'h0C, 32'h0, RESP_OKAY);
		wrc(8'h0C, 32'h2, RESP_OKAY);
		rdc(8'h0C, 32'h2, RESP_OKAY);
	endtask
	// ======
	// Main sequence, including a reset in mid-run
	initial begin
		{nrst, completion_flag, engine_quiet_flag, accept_next_flag} = 4'h0;
		{second_arg_consume, third_arg_out_strobe, third_arg_out} = '0;
		repeat (6) @(negedge clk);
		nrst = 1'b1;
		rdc(8'h2C, 32'h0, RESP_OKAY);
		chk(wide_address_option, 32'h1);
		t_start();
		t_args();
		t_hs();
		t_out();
		nrst = 1'b0;
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		rdc(8'h10, 32'h0, RESP_OKAY);
		summarize();
	end
endmodule
`default_nettype wire
